// File: rtl/pir_regs.sv
// Management frame slave with interrupt, loopback and cable test registers
`timescale 1ns/1ps
`default_nettype none
module pir_regs
	import pir_pkg::*;
#(
	parameter logic [4:0] PHY_ADDR = 5'h01
) (
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       sys_rst_i,
	// Management pins
	input  wire logic       mdc_i,
	input  wire logic       mdio_i,
	output logic            mdio_o,
	output logic            mdio_oe_n_o,
	// Line events, one bit per status flag
	input  wire logic [7:0] event_i,
	// Cable measurement from the analog front end
	input  wire logic [1:0] diag_fault_i,
	input  wire logic       diag_short_i,
	// Outputs to the rest of the PHY
	output logic            irq_o,
	output logic            loopback_o
);
	// Frame slave state
	logic         mdc_s1, mdc_s2, mdc_s3;
	logic         mdio_s1, mdio_s2;
	pir_mdio_st_e st, next_st;
	logic [5:0]   cnt, next_cnt;
	logic [12:0]  hdr, next_hdr;
	logic [15:0]  sh, next_sh;
	logic         hit, next_hit;
	logic         is_rd, next_rd;
	logic         next_mdio, next_oe_n;
	logic         rd_clr, next_rd_clr;
	logic         wr_stb, next_wr_stb;
	logic         mdc_rise;
	// Register bank state
	logic         loop_basic, next_loop_basic;
	logic [7:0]   ics_en, next_ics_en;
	logic [7:0]   stat, next_stat;
	logic [15:0]  func, next_func;
	logic         pol, next_pol;
	logic         diag_en, next_diag_en;
	logic         start, next_start;
	logic         next_irq, next_loop;
	logic [15:0]  rdata;
	logic [7:0]   clr;
	logic         wr_hit_diag;
	logic         pend;

	pir_diag_if dif();

	pir_diag u_diag (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.dif       (dif.eng)
	);

	assign dif.start    = start;
	assign dif.fault_in = diag_fault_i;
	assign dif.short_in = diag_short_i;

	// Only the second data stage feeds logic; the clock edge detect compares its second and third stages
	assign mdc_rise = mdc_s2 && !mdc_s3;

	// Frame sequencing; the slave samples and drives on rising clock edges
	always_comb begin
		next_st     = st;
		next_cnt    = cnt;
		next_hdr    = hdr;
		next_sh     = sh;
		next_hit    = hit;
		next_rd     = is_rd;
		next_mdio   = mdio_o;
		next_oe_n   = mdio_oe_n_o;
		next_rd_clr = 1'b0;
		next_wr_stb = 1'b0;
		if (mdc_rise) begin
			case (st)
				S_PRE: begin
					if (mdio_s2) begin
						if (cnt != PRE_ONES) begin
							next_cnt = cnt + 6'h01;
						end
					end else if (cnt == PRE_ONES) begin
						next_st  = S_HDR;
						next_cnt = 6'h00;
					end else begin
						next_cnt = 6'h00;
					end
				end
				S_HDR: begin
					next_hdr = {hdr[11:0], mdio_s2};
					if (cnt == HDR_LAST) begin
						next_st  = S_TA;
						next_cnt = 6'h00;
						next_rd  = (next_hdr[11:10] == OP_RD);
						// Second start bit, a known opcode and our address
						next_hit = next_hdr[12] && (next_hdr[9:5] == PHY_ADDR)
							&& (next_hdr[11:10] == OP_RD || next_hdr[11:10] == OP_WR);
					end else begin
						next_cnt = cnt + 6'h01;
					end
				end
				S_TA: begin
					if (cnt == 6'h00) begin
						next_cnt = 6'h01;
						if (hit && is_rd) begin
							next_oe_n   = 1'b0;
							next_mdio   = 1'b0;
							next_sh     = rdata;
							next_rd_clr = (hdr[4:0] == REG_ICS);
						end
					end else begin
						next_st  = S_DATA;
						next_cnt = 6'h00;
						if (hit && is_rd) begin
							next_mdio = sh[15];
							next_sh   = {sh[14:0], 1'b0};
						end
					end
				end
				S_DATA: begin
					next_sh = {sh[14:0], is_rd ? 1'b0 : mdio_s2};
					if (cnt == DATA_LAST) begin
						// Release the pin after the last data bit
						next_st     = S_PRE;
						next_cnt    = 6'h00;
						next_oe_n   = 1'b1;
						next_mdio   = 1'b0;
						next_wr_stb = hit && !is_rd;
					end else begin
						next_cnt  = cnt + 6'h01;
						next_mdio = is_rd ? sh[15] : 1'b0;
					end
				end
				default: begin
					next_st  = S_PRE;
					next_cnt = 6'h00;
				end
			endcase
		end
	end

	// Frame slave registers and pin synchronisers
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			mdc_s1      <= 1'b0;
			mdc_s2      <= 1'b0;
			mdc_s3      <= 1'b0;
			mdio_s1     <= 1'b1;
			mdio_s2     <= 1'b1;
			st          <= S_PRE;
			cnt         <= 6'h00;
			hdr         <= 13'h0000;
			sh          <= 16'h0000;
			hit         <= 1'b0;
			is_rd       <= 1'b0;
			mdio_o      <= 1'b0;
			mdio_oe_n_o <= 1'b1;
			rd_clr      <= 1'b0;
			wr_stb      <= 1'b0;
		end else begin
			mdc_s1      <= mdc_i;
			mdc_s2      <= mdc_s1;
			mdc_s3      <= mdc_s2;
			mdio_s1     <= mdio_i;
			mdio_s2     <= mdio_s1;
			st          <= next_st;
			cnt         <= next_cnt;
			hdr         <= next_hdr;
			sh          <= next_sh;
			hit         <= next_hit;
			is_rd       <= next_rd;
			mdio_o      <= next_mdio;
			mdio_oe_n_o <= next_oe_n;
			rd_clr      <= next_rd_clr;
			wr_stb      <= next_wr_stb;
		end
	end

	// Read data; unmapped addresses read as zero
	always_comb begin
		rdata = 16'h0000;
		case (hdr[4:0])
			REG_BASIC: rdata[BASIC_LOOP_BIT] = loop_basic;
			REG_ICS:   rdata = {ics_en, stat};
			REG_FUNC:  rdata = func;
			REG_DIAG: begin
				// enable reads one until results are valid
				rdata[DIAG_EN_BIT] = diag_en;
				rdata[DIAG_RES_LSB +: 2] = dif.result;
				rdata[DIAG_SHORT_BIT] = dif.short_cable;
			end
			REG_CTRL2: rdata[CTRL2_POL_BIT] = pol;
			default:   rdata = 16'h0000;
		endcase
	end

	// Clear only the flags that the read actually reported
	assign clr = rd_clr ? sh[7:0] : 8'h00;

	for (genvar k = 0; k < 8; k++) begin : g_stat
		assign next_stat[k] = (stat[k] && !clr[k]) || event_i[k];
	end

	assign wr_hit_diag = wr_stb && (hdr[4:0] == REG_DIAG);
	assign pend        = |(stat & ics_en);

	// Register writes and derived outputs
	always_comb begin
		next_loop_basic = loop_basic;
		next_ics_en     = ics_en;
		next_func       = func;
		next_pol        = pol;
		if (wr_stb) begin
			case (hdr[4:0])
				REG_BASIC: next_loop_basic = sh[BASIC_LOOP_BIT];
				REG_ICS:   next_ics_en = sh[15:ICS_EN_LSB];
				REG_FUNC:  next_func = sh;
				REG_CTRL2: next_pol = sh[CTRL2_POL_BIT];
				default:   next_func = func;
			endcase
		end
		// start on write of one, cleared at completion
		next_start   = wr_hit_diag && sh[DIAG_EN_BIT] && !diag_en;
		next_diag_en = (diag_en && !dif.done) || next_start;
		next_irq  = pol ? pend : !pend;
		next_loop = loop_basic && func[FUNC_LOOP_BIT];
	end

	// Register bank flip-flops
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			loop_basic <= 1'b0;
			ics_en     <= ICS_EN_RST;
			stat       <= ICS_STAT_RST;
			func       <= FUNC_RST;
			pol        <= 1'b0;
			diag_en    <= 1'b0;
			start      <= 1'b0;
			irq_o      <= 1'b1;
			loopback_o <= 1'b0;
		end else begin
			loop_basic <= next_loop_basic;
			ics_en     <= next_ics_en;
			stat       <= next_stat;
			func       <= next_func;
			pol        <= next_pol;
			diag_en    <= next_diag_en;
			start      <= next_start;
			irq_o      <= next_irq;
			loopback_o <= next_loop;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	a_stat_event_set: assert property (|event_i
		|=> (stat & $past(event_i)) == $past(event_i))
		else $error("event did not set its flag");
	a_stat_read_clear: assert property (rd_clr && event_i == 8'h00
		|=> (stat & $past(sh[7:0])) == 8'h00)
		else $error("reported flag not cleared by read");
	a_stat_hold: assert property (!rd_clr && event_i == 8'h00 |=> $stable(stat))
		else $error("flag changed without cause");
	a_enable_write: assert property (wr_stb && hdr[4:0] == REG_ICS
		|=> ics_en == $past(sh[15:8]))
		else $error("interrupt enables not written");
	a_irq_polarity: assert property (pend && $stable(pol) |=> irq_o == pol)
		else $error("interrupt level wrong for polarity");
	// Pin level trails a polarity write by one cycle, so compare against the old bit
	a_irq_idle: assert property (!pend ##1 !pend |-> irq_o == !$past(pol))
		else $error("interrupt active with nothing pending");
	a_loop_both: assert property (loopback_o
		|-> $past(loop_basic) && $past(func[FUNC_LOOP_BIT]))
		else $error("loopback without both control bits");
	a_diag_selfclr: assert property (dif.done && !next_start |=> !diag_en)
		else $error("test enable not cleared at completion");
	a_diag_busy_seen: assert property (start |-> diag_en ##1 dif.busy && diag_en)
		else $error("test enable low while test runs");
	a_mdio_drive: assert property (!mdio_oe_n_o |-> hit && is_rd && (st == S_TA || st == S_DATA))
		else $error("pin driven outside a read frame");

	c_read_frame: cover property (rd_clr);
	c_write_frame: cover property (wr_stb && hit);
	c_irq_active: cover property (pend && irq_o == pol);
	c_diag_done: cover property (dif.done && diag_en);
endmodule : pir_regs
`default_nettype wire

// File: rtl/pir_pkg.sv
// Constants and types for the PHY interrupt, loopback and cable test registers
// Summary of operation
// - Link event interrupt enables at bits 11:8
// - Jabber status bit 7, clears on read
// - Receive error status bit 6, clears on read
// - Page received status bit 5, clears on read
// - Parallel detect fault bit 4, clears on read
// - Partner acknowledge status bit 3, clears on read
// - Link down status bit 2, clears on read
// - Remote fault status bit 1, clears on read
// - Link up status bit 0, clears on read
// - Loopback needs both control bits set
// - Test enable bit self-clears when test completes
// - Results valid once enable reads zero
// - Result field 14:13 encodes test outcome
// - Bit 12 flags cable under ten metres
// - Upper interrupt enables at bits 15:12
// - Polarity bit selects interrupt output level
package pir_pkg;
	// Register addresses
	localparam logic [4:0]  REG_BASIC      = 5'h00;
	localparam logic [4:0]  REG_ICS        = 5'h1b;
	localparam logic [4:0]  REG_FUNC       = 5'h1c;
	localparam logic [4:0]  REG_DIAG       = 5'h1d;
	localparam logic [4:0]  REG_CTRL2      = 5'h1f;
	// Field positions
	localparam int          BASIC_LOOP_BIT = 14;
	localparam int          ICS_EN_LSB     = 8;
	localparam int          FUNC_LOOP_BIT  = 5;
	localparam int          DIAG_EN_BIT    = 15;
	localparam int          DIAG_RES_LSB   = 13;
	localparam int          DIAG_SHORT_BIT = 12;
	localparam int          CTRL2_POL_BIT  = 9;
	// Values after reset
	localparam logic [7:0]  ICS_EN_RST     = 8'h00;
	localparam logic [7:0]  ICS_STAT_RST   = 8'h00;
	localparam logic [15:0] FUNC_RST       = 16'h0010;
	// Management frame: preamble ones, bits after start zero, data bits
	localparam logic [5:0]  PRE_ONES       = 6'h20;
	localparam logic [5:0]  HDR_LAST       = 6'h0c;
	localparam logic [5:0]  DATA_LAST      = 6'h0f;
	localparam logic [1:0]  OP_WR          = 2'b01;
	localparam logic [1:0]  OP_RD          = 2'b10;
	// Cable test duration, rounded up to whole cycles
	localparam int          CLK_PERIOD_NS  = 10;
	localparam int          DIAG_TIME_NS   = 1000;
	localparam int          DIAG_CYCLES    = (DIAG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0]  DIAG_LOAD      = 8'(DIAG_CYCLES - 1);
	// Cable test outcome codes
	typedef enum logic [1:0] {
		RES_NORMAL = 2'b00,
		RES_OPEN   = 2'b01,
		RES_SHORT  = 2'b10,
		RES_FAIL   = 2'b11
	} pir_diag_res_e;
	// Management frame states
	typedef enum logic [3:0] {
		S_PRE  = 4'b0001,
		S_HDR  = 4'b0010,
		S_TA   = 4'b0100,
		S_DATA = 4'b1000
	} pir_mdio_st_e;
	// Cable test engine states
	typedef enum logic [1:0] {
		D_IDLE = 2'b01,
		D_RUN  = 2'b10
	} pir_diag_st_e;
endpackage : pir_pkg

// File: rtl/pir_diag_if.sv
// Signals between the register bank and the cable test engine
`timescale 1ns/1ps
`default_nettype none
interface pir_diag_if;
	logic       start;
	logic       busy;
	logic       done;
	logic [1:0] result;
	logic       short_cable;
	logic [1:0] fault_in;
	logic       short_in;
	modport ctl (output start, fault_in, short_in, input busy, done, result, short_cable);
	modport eng (input start, fault_in, short_in, output busy, done, result, short_cable);
endinterface : pir_diag_if
`default_nettype wire

// File: rtl/pir_diag.sv
// Cable test engine: timed run, then latches outcome and short cable flag
`timescale 1ns/1ps
`default_nettype none
module pir_diag
	import pir_pkg::*;
(
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic sys_rst_i,
	// Register bank side
	pir_diag_if.eng   dif
);
	pir_diag_st_e st, next_st;
	logic [7:0]   cnt, next_cnt;
	logic         done, next_done;
	logic [1:0]   res, next_res;
	logic         shrt, next_shrt;

	// Next state of the engine
	always_comb begin
		next_st   = st;
		next_cnt  = cnt;
		next_done = 1'b0;
		next_res  = res;
		next_shrt = shrt;
		case (st)
			D_IDLE: begin
				if (dif.start) begin
					next_st  = D_RUN;
					next_cnt = DIAG_LOAD;
				end
			end
			D_RUN: begin
				if (cnt == 8'h00) begin
					next_res  = dif.fault_in;
					next_shrt = dif.short_in;
					next_done = 1'b1;
					next_st   = D_IDLE;
				end else begin
					next_cnt = cnt - 8'h01;
				end
			end
			default: next_st = D_IDLE;
		endcase
	end

	// Engine registers
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			st   <= D_IDLE;
			cnt  <= 8'h00;
			done <= 1'b0;
			res  <= RES_NORMAL;
			shrt <= 1'b0;
		end else begin
			st   <= next_st;
			cnt  <= next_cnt;
			done <= next_done;
			res  <= next_res;
			shrt <= next_shrt;
		end
	end

	assign dif.busy        = (st == D_RUN);
	assign dif.done        = done;
	assign dif.result      = res;
	assign dif.short_cable = shrt;

	localparam int DONE_DLY = DIAG_CYCLES + 1;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	a_diag_run_len: assert property (dif.start && st == D_IDLE |-> ##DONE_DLY done)
		else $error("cable test did not finish on time");
	a_diag_result_latch: assert property (done |-> res == $past(dif.fault_in)
		&& shrt == $past(dif.short_in))
		else $error("cable test outcome not latched");
	c_diag_open: cover property (done && res == RES_OPEN);
endmodule : pir_diag
`default_nettype wire

// File: verif/pir_smi_mst.sv
// Station management controller model that issues serial management frames
`timescale 1ns/1ps
`default_nettype none
module pir_smi_mst #(
	parameter logic [4:0] PHY = 5'h01
) (
	// Management pins as seen by the device
	output logic      mdc_o,
	output logic      line_o,
	input  wire logic dev_mdio_i,
	input  wire logic dev_oe_n_i
);
	logic       drv;
	logic       bit_q;
	logic [4:0] phy_adr;

	// Pull-up holds the line high when neither side drives it
	assign line_o = !dev_oe_n_i ? dev_mdio_i : (drv ? bit_q : 1'b1);

	// Clock stands low between frames
	initial begin
		mdc_o = 1'b0;
		drv   = 1'b0;
		bit_q = 1'b1;
		// Frame address; the bench may point it at another device
		phy_adr = PHY;
	end

	// One whole frame; data changes after the falling edge, sampled on the rising one
	task automatic xfer(input logic rd, input logic [4:0] ra, input logic [15:0] wd,
		output logic [15:0] rdat);
		logic [63:0] fr;
		fr   = {32'hffffffff, 2'b01, (rd ? 2'b10 : 2'b01), phy_adr, ra, 2'b10, wd};
		rdat = '0;
		for (int k = 0; k < 64; k++) begin
			drv   = !(rd && k >= 46);
			bit_q = fr[63-k];
			#62.5 mdc_o = 1'b1;
			if (rd && k >= 48) rdat = {rdat[14:0], line_o};
			#62.5 mdc_o = 1'b0;
		end
		drv = 1'b0;
		// Idle gap lets a write land before the next look at the outputs
		#100;
	endtask : xfer
endmodule : pir_smi_mst
`default_nettype wire

// File: verif/tb_pir_regs.sv
// Self-checking bench for the interrupt, loopback and cable test registers
`timescale 1ns/1ps
`default_nettype none
module tb_pir_regs
	import pir_pkg::*;
;
	logic        clk_i        = 1'b0;
	logic        sys_rst_i    = 1'b1;
	logic [7:0]  event_i      = 8'h00;
	logic [1:0]  diag_fault_i = 2'h0;
	logic        diag_short_i = 1'b0;
	logic        mdc;
	logic        line;
	logic        mdio_o;
	logic        oe_n;
	logic        irq_o;
	logic        loopback_o;
	logic [15:0] rd;
	logic [7:0]  en;
	logic        sh;
	int          seed = 32'h605c;
	int          mismatches = 0;
	int          comparisons = 0;
	int          n;

	always #5 clk_i = ~clk_i;

	pir_regs #(.PHY_ADDR(5'h01)) dut (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .mdc_i(mdc), .mdio_i(line),
		.mdio_o(mdio_o), .mdio_oe_n_o(oe_n), .event_i(event_i),
		.diag_fault_i(diag_fault_i), .diag_short_i(diag_short_i),
		.irq_o(irq_o), .loopback_o(loopback_o)
	);

	pir_smi_mst #(.PHY(5'h01)) mst (
		.mdc_o(mdc), .line_o(line), .dev_mdio_i(mdio_o), .dev_oe_n_i(oe_n)
	);

	// Expected pin level from polarity and pending state
	function automatic logic irq_lvl(input logic pol, input logic act);
		return act ? pol : !pol;
	endfunction : irq_lvl

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		logic [15:0] x;
		mst.xfer(1'b0, a, d, x);
	endtask : wr

	task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
		mst.xfer(1'b1, a, 16'h0000, rd);
		check(rd, exp);
	endtask : rd_chk

	task automatic pulse(input logic [7:0] ev);
		@(posedge clk_i);
		#1 event_i = ev;
		@(posedge clk_i);
		#1 event_i = 8'h00;
		repeat (3) @(posedge clk_i);
	endtask : pulse

	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : finish_test

	// Each flag set by its event, seen once, then cleared by that read
	task automatic ev_sweep(input logic pol, input logic [7:0] m);
		wr(REG_ICS, {m, 8'hff});
		rd_chk(REG_ICS, {m, 8'h00});
		for (int i = 0; i < 8; i++) begin
			pulse(8'h01 << i);
			check({15'h0, irq_o}, {15'h0, irq_lvl(pol, m[i])});
			rd_chk(REG_ICS, {m, 8'h01 << i});
			rd_chk(REG_ICS, {m, 8'h00});
			check({15'h0, irq_o}, {15'h0, irq_lvl(pol, 1'b0)});
		end
	endtask : ev_sweep

	initial begin
		repeat (5) @(posedge clk_i);
		#1 sys_rst_i = 1'b0;
		repeat (3) @(posedge clk_i);
		// Defaults after reset, plus an unmapped place
		rd_chk(REG_ICS, 16'h0000);
		rd_chk(REG_FUNC, FUNC_RST);
		rd_chk(REG_DIAG, 16'h0000);
		rd_chk(5'h05, 16'h0000);
		check({15'h0, irq_o}, 16'h0001);
		check({15'h0, loopback_o}, 16'h0000);
		$display("test reset done");

		// Low polarity with random enables, then high polarity with all enabled
		en = 8'($random(seed));
		ev_sweep(1'b0, en);
		wr(REG_CTRL2, 16'h0200);
		check({15'h0, irq_o}, 16'h0000);
		rd_chk(REG_CTRL2, 16'h0200);
		ev_sweep(1'b1, 8'hff);
		// A frame for another address must leave the registers alone
		mst.phy_adr = 5'h02;
		wr(REG_ICS, 16'h0000);
		mst.phy_adr = 5'h01;
		rd_chk(REG_ICS, 16'hff00);
		$display("test events done");

		// controller sets both loopback bits, in every combination
		for (int k = 0; k < 4; k++) begin
			wr(REG_BASIC, {1'b0, k[1], 14'h0000});
			wr(REG_FUNC, FUNC_RST | {10'h000, k[0], 5'h00});
			rd_chk(REG_BASIC, {1'b0, k[1], 14'h0000});
			check({15'h0, loopback_o}, {15'h0, (k == 3)});
		end
		$display("test loopback done");

		// Every outcome code with a random short cable flag
		for (int c = 0; c < 4; c++) begin
			sh = 1'($random(seed));
			@(posedge clk_i);
			#1 diag_fault_i = c[1:0];
			diag_short_i = sh;
			// start the test by setting the enable bit
			wr(REG_DIAG, 16'h8000);
			// poll until the enable bit reads zero, bounded
			n = 0;
			do begin
				mst.xfer(1'b1, REG_DIAG, 16'h0000, rd);
				n++;
			end while (rd[15] !== 1'b0 && n < 4);
			if (rd[15] !== 1'b0) begin
				mismatches++;
				finish_test();
			end
			check(rd, {1'b0, c[1:0], sh, 12'h000});
		end
		$display("test cable done");
		finish_test();
	end
endmodule : tb_pir_regs
`default_nettype wire
